/* File: pcr_pkg.sv */
// pcr_pkg: constants for the power / plug-and-play configuration block
// assumes: byte-wide isa-style host accesses, one 50 MHz clock
package pcr_pkg;

  // ------------------------------------------------------------------
  // clock and widths
  // ------------------------------------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int DW = 8;
  localparam int AW = 16;

  // ------------------------------------------------------------------
  // main register group, page 3 offsets
  // ------------------------------------------------------------------
  localparam logic [AW-1:0] GROUP_SPAN = 16'h0020;
  localparam logic [4:0] OFF_POWER_LED_CONFIG = 5'h06;
  localparam logic [4:0] OFF_CARD_NUMBER_BACKUP = 5'h08;
  localparam logic [4:0] OFF_HALT_CLOCK_SELECT = 5'h09;
  localparam logic [4:0] OFF_INTERRUPT_LINE_MIRROR = 5'h0b;
  localparam logic [4:0] OFF_FLASH_WRITE_UNLOCK = 5'h0c;
  localparam logic [4:0] OFF_DECODE_WIDTH_CONFIG = 5'h0d;

  // power_led_config bit positions
  localparam int BIT_SLEEP = 2;
  localparam int BIT_POWER_DOWN = 1;
  localparam int BIT_INACTIVE = 0;
  // decode_width_config bit position
  localparam int BIT_FULL_DECODE = 0;

  // halt-clock select codes
  localparam logic [DW-1:0] HALT_CODE_RUN = 8'h52;
  localparam logic [DW-1:0] HALT_CODE_STOP = 8'h48;

  // flash unlock sequence
  localparam logic [DW-1:0] UNLOCK_FIRST = 8'h57;
  localparam logic [DW-1:0] UNLOCK_SECOND = 8'ha8;

  // ------------------------------------------------------------------
  // plug-and-play ports and indices
  // ------------------------------------------------------------------
  localparam logic [11:0] PNP_INDEX_PORT = 12'h279;
  localparam logic [11:0] PNP_WRITE_PORT = 12'ha79;
  localparam logic [1:0] PNP_READ_LOW_BITS = 2'b11;
  localparam logic [DW-1:0] IDX_SET_READ_PORT = 8'h00;
  localparam logic [DW-1:0] IDX_CONFIG_CONTROL = 8'h02;
  localparam logic [DW-1:0] IDX_CARD_SELECT = 8'h06;
  localparam logic [DW-1:0] IDX_ACTIVATE = 8'h30;
  localparam int CC_RESET_BIT = 0;
  localparam int CC_RESET_CSN_BIT = 2;

  // reset values
  localparam logic [DW-1:0] RST_BYTE = 8'h00;

  // unlock sequence states
  typedef enum logic [0:0] {
    PCR_UNLOCK_IDLE,
    PCR_UNLOCK_GOT_FIRST
  } pcr_unlock_t;

endpackage

/* File: pcr_power_pnp_regs.sv */
// pcr_power_pnp_regs: power-management, decode and plug-and-play port
// logic of an isa network controller.
// assumes: host strobes ior_n / iow_n and sa / sd_in are synchronous to
// clk and held for at least two clock cycles per access; the command
// page register lives outside and reports page 3 on page3_sel.

module pcr_power_pnp_regs
  import pcr_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [AW-1:0] sa,
  input wire logic [DW-1:0] sd_in,
  output logic [DW-1:0] sd_out,
  output logic sd_oe,
  input wire logic ior_n,
  input wire logic iow_n,
  input wire logic [AW-1:0] io_base,
  input wire logic page3_sel,
  input wire logic config_write_mode_hi,
  input wire logic config_write_mode_lo,
  input wire logic eeprom_load,
  input wire logic eeprom_power_down,
  input wire logic eeprom_full_decode,
  input wire logic [7:0] interrupt_request_pins,
  input wire logic [2:0] led_in,
  input wire logic coax_led_in,
  output logic [2:0] led_out,
  output logic coax_activity_led,
  output logic net_enable,
  output logic clock_halt,
  output logic main_group_enable,
  output logic boot_rom_enable,
  input wire logic dma_active,
  output logic buffer_memory_select,
  input wire logic flash_wr_req,
  output logic flash_wr_out,
  output logic [DW-1:0] pnp_index,
  output logic pnp_wr_stb,
  output logic [DW-1:0] pnp_wr_data,
  input wire logic [DW-1:0] pnp_rd_data,
  output logic key_stb,
  output logic [DW-1:0] key_data
);

  // ------------------------------------------------------------------
  // local constants
  // ------------------------------------------------------------------
  // led level that turns every led off
  localparam logic [2:0] LED_ALL_OFF = 3'h7;
  // main_offset result for an address outside the group
  localparam logic [4:0] OFF_NONE = 5'h1f;
  // sa bit that keeps the read port inside the 200h-3ffh range
  localparam int RD_PORT_HI_BIT = 9;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------

  // offset of sa inside the main group, or all ones when outside it
  function automatic logic [4:0] main_offset(input logic [AW-1:0] a,
                                             input logic [AW-1:0] base,
                                             input logic full);
    logic [AW-1:0] rel;
    rel = full ? (a - base) : {6'h00, a[9:0] - base[9:0]};
    if (rel < GROUP_SPAN) begin
      main_offset = rel[4:0];
    end else begin
      main_offset = OFF_NONE;
    end
  endfunction

  // 12-bit port compare used for the fixed pnp ports
  function automatic logic port_hit(input logic [AW-1:0] a,
                                    input logic [11:0] port);
    port_hit = (a[11:0] == port);
  endfunction

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  logic iow_n_q, ior_n_q;
  logic sleep_q, sleep_d;
  logic power_down_bit_q, power_down_bit_d;
  logic halt_q, halt_d;
  logic full_q, full_d;
  logic active_q, active_d;
  logic [DW-1:0] csn_q, csn_d;
  logic [DW-1:0] rdport_q, rdport_d;
  logic [DW-1:0] index_q, index_d;
  pcr_unlock_t unlock_q, unlock_d;
  logic flash_en_q, flash_en_d;
  logic [DW-1:0] sd_out_q, sd_out_d;
  logic rd_act_q, rd_act_d;
  logic pnp_wr_stb_q, pnp_wr_stb_d;
  logic [DW-1:0] pnp_wr_data_q, pnp_wr_data_d;
  logic key_stb_q, key_stb_d;
  logic [DW-1:0] key_data_q, key_data_d;
  logic [2:0] led_q, led_d;
  logic coax_q, coax_d;
  logic bms_q, bms_d;
  logic flash_wr_q, flash_wr_d;

  // ------------------------------------------------------------------
  // access decode
  // ------------------------------------------------------------------
  logic wr_edge, rd_edge, mode_ok, halted, main_open;
  logic [4:0] moff;
  logic pg3, idx_wr, dat_wr, pnp_rd;

  assign wr_edge = iow_n_q & ~iow_n;
  assign rd_edge = ior_n_q & ~ior_n;
  assign mode_ok = config_write_mode_hi & config_write_mode_lo;
  assign halted = power_down_bit_q & halt_q;
  // main group closed while inactive or clock halted
  assign main_open = active_q & ~halted;
  assign moff = main_offset(sa, io_base, full_q);
  assign pg3 = page3_sel & (moff != OFF_NONE);
  // fixed write-only ports and relocatable read port
  assign idx_wr = wr_edge & port_hit(sa, PNP_INDEX_PORT);
  assign dat_wr = wr_edge & port_hit(sa, PNP_WRITE_PORT);
  // read port only answers in the upper half of the ten-bit range, so an
  // unprogrammed read port (index 00 still zero) cannot grab low addresses
  assign pnp_rd = sa[RD_PORT_HI_BIT] &
                  (sa[9:0] == {rdport_q, PNP_READ_LOW_BITS});

  // ------------------------------------------------------------------
  // pnp ports and bus read path
  // ------------------------------------------------------------------

  // index latch, data writes to the selected index, read mux
  always_comb begin
    index_d = index_q;
    csn_d = csn_q;
    rdport_d = rdport_q;
    active_d = active_q;
    pnp_wr_stb_d = 1'b0;
    pnp_wr_data_d = pnp_wr_data_q;
    key_stb_d = 1'b0;
    key_data_d = key_data_q;
    sd_out_d = sd_out_q;
    rd_act_d = rd_act_q & ~ior_n;
    if (idx_wr) begin
      index_d = sd_in;
      key_stb_d = 1'b1;
      key_data_d = sd_in;
    end
    // index stays put, so data accesses may repeat freely
    if (dat_wr) begin
      pnp_wr_stb_d = 1'b1;
      pnp_wr_data_d = sd_in;
      unique case (index_q)
        IDX_SET_READ_PORT: rdport_d = sd_in;
        IDX_CARD_SELECT: csn_d = sd_in;
        IDX_ACTIVATE: active_d = sd_in[0];
        IDX_CONFIG_CONTROL: begin
          if (sd_in[CC_RESET_BIT]) begin
            active_d = 1'b0;
          end
          if (sd_in[CC_RESET_CSN_BIT]) begin
            csn_d = RST_BYTE;
          end
        end
        default: ;
      endcase
    end
    if (rd_edge && pnp_rd) begin
      rd_act_d = 1'b1;
      unique case (index_q)
        IDX_SET_READ_PORT: sd_out_d = rdport_q;
        IDX_CARD_SELECT: sd_out_d = csn_q;
        IDX_ACTIVATE: sd_out_d = {7'h00, active_q};
        default: sd_out_d = pnp_rd_data;
      endcase
    end else if (rd_edge && pg3 && main_open) begin
      rd_act_d = 1'b1;
      unique case (moff)
        OFF_POWER_LED_CONFIG: begin
          sd_out_d = RST_BYTE;
          sd_out_d[BIT_SLEEP] = sleep_q;
          sd_out_d[BIT_POWER_DOWN] = power_down_bit_q;
          sd_out_d[BIT_INACTIVE] = ~active_q;
        end
        OFF_CARD_NUMBER_BACKUP: sd_out_d = csn_q;
        OFF_INTERRUPT_LINE_MIRROR: begin
          sd_out_d = interrupt_request_pins;
        end
        OFF_DECODE_WIDTH_CONFIG: begin
          sd_out_d = RST_BYTE;
          sd_out_d[BIT_FULL_DECODE] = full_q;
        end
        default: begin
          rd_act_d = 1'b0; // write-only or unmapped: no drive
        end
      endcase
    end
  end

  // registers of the port and read path
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      index_q <= RST_BYTE;
      csn_q <= RST_BYTE;
      rdport_q <= RST_BYTE;
      active_q <= 1'b0;
      pnp_wr_stb_q <= 1'b0;
      pnp_wr_data_q <= RST_BYTE;
      key_stb_q <= 1'b0;
      key_data_q <= RST_BYTE;
      sd_out_q <= RST_BYTE;
      rd_act_q <= 1'b0;
      iow_n_q <= 1'b1;
      ior_n_q <= 1'b1;
    end else begin
      index_q <= index_d;
      csn_q <= csn_d;
      rdport_q <= rdport_d;
      active_q <= active_d;
      pnp_wr_stb_q <= pnp_wr_stb_d;
      pnp_wr_data_q <= pnp_wr_data_d;
      key_stb_q <= key_stb_d;
      key_data_q <= key_data_d;
      sd_out_q <= sd_out_d;
      rd_act_q <= rd_act_d;
      iow_n_q <= iow_n;
      ior_n_q <= ior_n;
    end
  end

  // ------------------------------------------------------------------
  // power management, decode strap and flash unlock
  // ------------------------------------------------------------------
  logic mwr;
  assign mwr = wr_edge & pg3;

  always_comb begin
    sleep_d = sleep_q;
    power_down_bit_d = power_down_bit_q;
    halt_d = halt_q;
    full_d = full_q;
    unlock_d = unlock_q;
    flash_en_d = flash_en_q;
    // straps caught after reset release
    if (eeprom_load) begin
      power_down_bit_d = eeprom_power_down;
      full_d = eeprom_full_decode;
    end
    // power config: both write-mode bits needed; reserved bit not stored
    if (mwr && main_open && moff == OFF_POWER_LED_CONFIG && mode_ok) begin
      sleep_d = sd_in[BIT_SLEEP];
      power_down_bit_d = sd_in[BIT_POWER_DOWN];
    end
    // halt-clock: open even while inactive or halted
    if (mwr && moff == OFF_HALT_CLOCK_SELECT && power_down_bit_q) begin
      if (sd_in == HALT_CODE_RUN) begin
        halt_d = 1'b0;
      end else if (sd_in == HALT_CODE_STOP) begin
        halt_d = 1'b1;
      end
    end
    // two-byte unlock; any other byte relocks
    if (mwr && main_open && moff == OFF_FLASH_WRITE_UNLOCK && mode_ok) begin
      unique case (unlock_q)
        PCR_UNLOCK_IDLE: begin
          flash_en_d = 1'b0;
          unlock_d = (sd_in == UNLOCK_FIRST) ? PCR_UNLOCK_GOT_FIRST
                                               : PCR_UNLOCK_IDLE;
        end
        PCR_UNLOCK_GOT_FIRST: begin
          flash_en_d = (sd_in == UNLOCK_SECOND);
          unlock_d = PCR_UNLOCK_IDLE;
        end
      endcase
    end
  end

  // power and unlock registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sleep_q <= 1'b0;
      power_down_bit_q <= 1'b0;
      halt_q <= 1'b0;
      full_q <= 1'b0;
      unlock_q <= PCR_UNLOCK_IDLE;
      flash_en_q <= 1'b0;
    end else begin
      sleep_q <= sleep_d;
      power_down_bit_q <= power_down_bit_d;
      halt_q <= halt_d;
      full_q <= full_d;
      unlock_q <= unlock_d;
      flash_en_q <= flash_en_d;
    end
  end

  // ------------------------------------------------------------------
  // pin outputs
  // ------------------------------------------------------------------

  // led forcing, buffer standby and flash gating
  always_comb begin
    led_d = led_in;
    coax_d = coax_led_in;
    if (power_down_bit_q) begin
      led_d = LED_ALL_OFF;
      coax_d = 1'b0;
    end else if (sleep_q) begin
      led_d = LED_ALL_OFF;
    end
    bms_d = ~dma_active;
    flash_wr_d = flash_wr_req & flash_en_q;
  end

  // output flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      led_q <= LED_ALL_OFF;
      coax_q <= 1'b0;
      bms_q <= 1'b1;
      flash_wr_q <= 1'b0;
    end else begin
      led_q <= led_d;
      coax_q <= coax_d;
      bms_q <= bms_d;
      flash_wr_q <= flash_wr_d;
    end
  end

  assign led_out = led_q;
  assign coax_activity_led = coax_q;
  assign buffer_memory_select = bms_q;
  assign flash_wr_out = flash_wr_q;
  // network keeps running in sleep, stops in power-down
  assign net_enable = ~power_down_bit_q;
  assign clock_halt = halted;
  assign main_group_enable = main_open;
  assign boot_rom_enable = main_open;
  assign sd_out = sd_out_q;
  assign sd_oe = rd_act_q;
  assign pnp_index = index_q;
  assign pnp_wr_stb = pnp_wr_stb_q;
  assign pnp_wr_data = pnp_wr_data_q;
  assign key_stb = key_stb_q;
  assign key_data = key_data_q;

endmodule

/* File: pcr_power_pnp_regs_chk_asserts.sv */
// pcr_power_pnp_regs_chk: port-level checks for the power/pnp block
// assumes: bound onto pcr_power_pnp_regs, one clock, rstn active low
module pcr_power_pnp_regs_chk
  import pcr_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [AW-1:0] sa,
  input wire logic [DW-1:0] sd_in,
  input wire logic ior_n,
  input wire logic sd_oe,
  input wire logic [2:0] led_out,
  input wire logic coax_activity_led,
  input wire logic net_enable,
  input wire logic clock_halt,
  input wire logic main_group_enable,
  input wire logic boot_rom_enable,
  input wire logic dma_active,
  input wire logic buffer_memory_select,
  input wire logic flash_wr_req,
  input wire logic flash_wr_out,
  input wire logic key_stb,
  input wire logic [DW-1:0] key_data,
  input wire logic pnp_wr_stb,
  input wire logic [DW-1:0] pnp_wr_data
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // ----------------------------------------------------------------
  // power and gating relations
  // ----------------------------------------------------------------
  AST_PD_LEDS: assert property (!net_enable && !$past(net_enable) |->
    led_out == 3'b111 && !coax_activity_led)
    else $error("leds not forced in power-down");
  AST_HALT_PD: assert property (clock_halt |-> !net_enable)
    else $error("clock halted outside power-down");
  AST_HALT_GATE: assert property (clock_halt |-> !main_group_enable)
    else $error("main group open while halted");
  AST_ROM_GATE: assert property (boot_rom_enable == main_group_enable)
    else $error("boot rom gate differs from main group gate");
  AST_BMS: assert property ($past(rstn, 2) |->
    buffer_memory_select == !$past(dma_active))
    else $error("buffer select does not follow dma");
  AST_FLASH: assert property (flash_wr_out |-> $past(flash_wr_req))
    else $error("flash write without request");

  // ----------------------------------------------------------------
  // pnp port strobes and read release
  // ----------------------------------------------------------------
  AST_KEY: assert property (key_stb |-> $past(sa[11:0]) == PNP_INDEX_PORT
    && key_data == $past(sd_in) ##1 !key_stb)
    else $error("key strobe wrong");
  AST_WR_PORT: assert property (pnp_wr_stb |->
    $past(sa[11:0]) == PNP_WRITE_PORT && pnp_wr_data == $past(sd_in))
    else $error("write port strobe wrong");
  AST_READ_END: assert property ($rose(ior_n) |-> ##[1:2] !sd_oe)
    else $error("data bus held after read");

  COV_KEY: cover property (key_stb);
  COV_HALT: cover property (clock_halt);
  COV_FLASH: cover property (flash_wr_out);
  COV_READ: cover property (sd_oe);
endmodule

bind pcr_power_pnp_regs pcr_power_pnp_regs_chk chk (.clk(clk), .rstn(rstn),
  .sa(sa), .sd_in(sd_in), .ior_n(ior_n), .sd_oe(sd_oe), .led_out(led_out),
  .coax_activity_led(coax_activity_led), .net_enable(net_enable),
  .clock_halt(clock_halt), .main_group_enable(main_group_enable),
  .boot_rom_enable(boot_rom_enable), .dma_active(dma_active),
  .buffer_memory_select(buffer_memory_select), .flash_wr_req(flash_wr_req),
  .flash_wr_out(flash_wr_out), .key_stb(key_stb), .key_data(key_data),
  .pnp_wr_stb(pnp_wr_stb), .pnp_wr_data(pnp_wr_data));

/* File: pcr_isa_host.sv */
// pcr_isa_host: isa host model driving byte accesses into the block
// assumes: strobes set at a rising edge, held three clocks, high at least three
module pcr_isa_host
  import pcr_pkg::*;
(
  input wire logic clk,
  input wire logic [DW-1:0] sd_out,
  input wire logic sd_oe,
  output logic [AW-1:0] sa,
  output logic [DW-1:0] sd_in,
  output logic ior_n,
  output logic iow_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sa = 16'h0000;
    sd_in = 8'h00;
    ior_n = 1'b1;
    iow_n = 1'b1;
  end

  // one access; read data taken at the edge the strobe is released
  task automatic acc(input logic [AW-1:0] a, input logic [DW-1:0] d,
    input logic rd, output logic [DW-1:0] q, output logic drv);
    @(posedge clk);
    sa <= a;
    sd_in <= d;
    if (rd) ior_n <= 1'b0;
    else iow_n <= 1'b0;
    repeat (3) @(posedge clk);
    q = sd_out;
    drv = sd_oe;
    ior_n <= 1'b1;
    iow_n <= 1'b1;
    sd_in <= ~d; // released bus does not keep the last byte
    repeat (2) @(posedge clk);
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    logic [DW-1:0] q;
    logic drv;
    acc(a, d, 1'b0, q, drv);
  endtask

  // index is written once, then one data write to the write port
  task automatic pnp(input logic [DW-1:0] idx, input logic [DW-1:0] d);
    wr({4'h0, PNP_INDEX_PORT}, idx);
    wr({4'h0, PNP_WRITE_PORT}, d);
  endtask
endmodule

/* File: test_power_pnp_config_regs.sv */
// test_power_pnp_config_regs: directed bench for the power/pnp block
// assumes: pcr_isa_host drives the host bus, checker bound separately
module test_power_pnp_config_regs
  import pcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [AW-1:0] BASE = 16'h0300;
  logic clk, rstn, page3_sel, config_write_mode_hi, config_write_mode_lo;
  logic eeprom_load, eeprom_power_down, eeprom_full_decode, coax_led_in;
  logic dma_active, flash_wr_req, sd_oe, coax_activity_led, net_enable;
  logic clock_halt, main_group_enable, boot_rom_enable, buffer_memory_select;
  logic flash_wr_out, pnp_wr_stb, key_stb, ior_n, iow_n, drv;
  logic [AW-1:0] sa, io_base;
  logic [DW-1:0] sd_in, sd_out, pnp_index, pnp_wr_data, pnp_rd_data;
  logic [DW-1:0] key_data, q;
  logic [7:0] interrupt_request_pins;
  logic [2:0] led_in, led_out;
  int mismatches, n_checks, cycles;

  pcr_power_pnp_regs uut (.clk(clk), .rstn(rstn), .sa(sa), .sd_in(sd_in),
    .sd_out(sd_out), .sd_oe(sd_oe), .ior_n(ior_n), .iow_n(iow_n),
    .io_base(io_base), .page3_sel(page3_sel),
    .config_write_mode_hi(config_write_mode_hi),
    .config_write_mode_lo(config_write_mode_lo), .eeprom_load(eeprom_load),
    .eeprom_power_down(eeprom_power_down),
    .eeprom_full_decode(eeprom_full_decode),
    .interrupt_request_pins(interrupt_request_pins), .led_in(led_in),
    .coax_led_in(coax_led_in), .led_out(led_out),
    .coax_activity_led(coax_activity_led), .net_enable(net_enable),
    .clock_halt(clock_halt), .main_group_enable(main_group_enable),
    .boot_rom_enable(boot_rom_enable), .dma_active(dma_active),
    .buffer_memory_select(buffer_memory_select), .flash_wr_req(flash_wr_req),
    .flash_wr_out(flash_wr_out), .pnp_index(pnp_index),
    .pnp_wr_stb(pnp_wr_stb), .pnp_wr_data(pnp_wr_data),
    .pnp_rd_data(pnp_rd_data), .key_stb(key_stb), .key_data(key_data));
  pcr_isa_host host (.clk(clk), .sd_out(sd_out), .sd_oe(sd_oe), .sa(sa),
    .sd_in(sd_in), .ior_n(ior_n), .iow_n(iow_n));

  // ----------------------------------------------------------------
  // clock, timeout, compare and verdict
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    if (mismatches == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic rg_wr(input logic [4:0] off, input logic [DW-1:0] d);
    host.wr(BASE | off, d);
  endtask
  task automatic rg_rd(input logic [4:0] off);
    host.acc(BASE | off, 8'h00, 1'b1, q, drv);
  endtask
  task automatic modes(input logic m);
    @(posedge clk);
    config_write_mode_hi <= m;
    config_write_mode_lo <= m;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_activate();
    rg_rd(5'h0b);
    chk({7'h0, drv}, 8'h00);
    host.acc(16'h0003, 8'h00, 1'b1, q, drv);
    chk({7'h0, drv}, 8'h00);
    host.pnp(IDX_SET_READ_PORT, 8'h80);
    host.pnp(IDX_ACTIVATE, 8'h01);
    chk({7'h0, main_group_enable}, 8'h01);
    chk({6'h0, boot_rom_enable, buffer_memory_select}, 8'h02);
    repeat (2) begin
      host.acc(16'h0203, 8'h00, 1'b1, q, drv);
      chk(q, 8'h01);
    end
    rg_rd(5'h06);
    chk(q, 8'h00);
  endtask
  task automatic t_sleep();
    rg_wr(5'h06, 8'h04); // sleep bit 2 stays 0, write modes still off
    rg_rd(5'h06);
    chk(q, 8'h00);
    modes(1'b1);
    rg_wr(5'h06, 8'h04);
    rg_rd(5'h06);
    chk(q, 8'h04);
    chk({4'h0, led_out, coax_activity_led}, 8'h0f);
    chk({7'h0, net_enable}, 8'h01);
    rg_wr(5'h06, 8'h00);
    chk({5'h0, led_out}, 8'h02);
  endtask
  task automatic t_power();
    rg_wr(5'h09, 8'h48);
    chk({7'h0, clock_halt}, 8'h00);
    rg_wr(5'h06, 8'h02);
    chk({3'h0, net_enable, led_out, coax_activity_led}, 8'h0e);
    rg_rd(5'h06);
    chk(q, 8'h02);
    rg_wr(5'h09, 8'h33);
    chk({7'h0, clock_halt}, 8'h00);
    rg_wr(5'h09, 8'h48);
    rg_rd(5'h0b);
    chk({6'h0, clock_halt, drv}, 8'h02);
    rg_wr(5'h09, 8'h52);
    chk({6'h0, clock_halt, main_group_enable}, 8'h01);
    rg_wr(5'h06, 8'h00);
    chk({7'h0, net_enable}, 8'h01);
  endtask
  task automatic t_mirror();
    @(posedge clk);
    interrupt_request_pins <= 8'ha5;
    rg_rd(5'h0b);
    chk(q, 8'ha5);
    host.pnp(IDX_CARD_SELECT, 8'h05);
    chk(pnp_index, IDX_CARD_SELECT);
    chk(key_data, IDX_CARD_SELECT);
    chk(pnp_wr_data, 8'h05);
    rg_rd(5'h08);
    chk(q, 8'h05);
    pnp_rd_data <= 8'h3c;
    host.wr({4'h0, PNP_INDEX_PORT}, 8'h31);
    host.acc(16'h0203, 8'h00, 1'b1, q, drv);
    chk(q, 8'h3c);
    rg_rd(5'h09);
    chk({7'h0, drv}, 8'h00);
  endtask
  task automatic t_flash();
    @(posedge clk);
    flash_wr_req <= 1'b1;
    repeat (2) @(posedge clk);
    chk({7'h0, flash_wr_out}, 8'h00);
    rg_wr(5'h0c, 8'h57);
    rg_wr(5'h0c, 8'ha8);
    chk({7'h0, flash_wr_out}, 8'h01);
    rg_wr(5'h0c, 8'h11);
    chk({7'h0, flash_wr_out}, 8'h00);
    modes(1'b0);
    rg_wr(5'h0c, 8'h57);
    rg_wr(5'h0c, 8'ha8);
    chk({7'h0, flash_wr_out}, 8'h00);
  endtask
  task automatic t_decode();
    host.acc(16'h830b, 8'h00, 1'b1, q, drv);
    chk({7'h0, drv}, 8'h01);
    @(posedge clk);
    eeprom_full_decode <= 1'b1;
    eeprom_power_down <= 1'b1;
    eeprom_load <= 1'b1;
    @(posedge clk);
    eeprom_load <= 1'b0;
    host.acc(16'h830b, 8'h00, 1'b1, q, drv);
    chk({7'h0, drv}, 8'h00);
    chk({7'h0, net_enable}, 8'h00);
    rg_wr(5'h0d, 8'h00);
    rg_rd(5'h0d);
    chk(q, 8'h01);
    modes(1'b1);
    rg_wr(5'h06, 8'h00);
    chk({7'h0, net_enable}, 8'h01);
  endtask

  initial begin
    rstn = 1'b0;
    page3_sel = 1'b1;
    io_base = BASE;
    {config_write_mode_hi, config_write_mode_lo} = 2'b00;
    {eeprom_load, eeprom_power_down, eeprom_full_decode} = 3'b000;
    interrupt_request_pins = 8'h00;
    led_in = 3'b010;
    coax_led_in = 1'b1;
    dma_active = 1'b0;
    flash_wr_req = 1'b0;
    pnp_rd_data = 8'h00;
    repeat (20) @(posedge clk);
    chk({led_out, coax_activity_led, net_enable, clock_halt,
      buffer_memory_select, main_group_enable}, 8'hea);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    chk({5'h0, led_out}, 8'h02);
    dma_active <= 1'b1;
    t_activate();
    t_sleep();
    t_power();
    t_mirror();
    t_flash();
    t_decode();
    report_and_stop();
  end
endmodule
